/* src/fsp_ctrl.v */
// flash self-program controller: read, row erase, latched block write
`default_nettype none
`include "fsp_consts.vh"
module fsp_ctrl #(
  parameter PROG_CYCLES = `FSP_PROG_CYCLES
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_rst_b,
  // register port
  input wire [2:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // core control
  input wire i_code_protect,
  output wire o_core_halt,
  output wire o_skip_slot
);
  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_SETUP = 3'h1;
  localparam ST_BUSY = 3'h2;
  localparam ST_COMMIT = 3'h3;
  localparam ST_DONE = 3'h4;
  localparam OP_ERASE = 2'h0;
  localparam OP_LOAD = 2'h1;
  localparam OP_WRITE = 2'h2;
  // the long count is 28 bits wide, enough for the full 2 ms at 100 MHz
  localparam [31:0] PROG_SPAN = PROG_CYCLES - 1;
  localparam [27:0] PROG_LAST = PROG_SPAN[27:0];
  function wr_hit;
    input [2:0] a;
    input [2:0] off;
    input w;
    begin
      wr_hit = w && (a == off);
    end
  endfunction
  function halting;
    input [2:0] s;
    begin
      halting = (s == ST_SETUP) || (s == ST_BUSY) || (s == ST_COMMIT);
    end
  endfunction
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [7:0] addr_lo_ff;
  reg [5:0] addr_hi_ff;
  reg [7:0] word_lo_ff;
  reg [5:0] word_hi_ff;
  reg [7:0] ctrl_ff;
  reg [1:0] key_ff;
  reg [1:0] rd_pipe_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [1:0] op_ff;
  reg [27:0] cnt_ff;
  reg [4:0] lat_idx_ff;
  reg [13:0] latch_ff [0:31];
  wire [10:0] full_addr = {addr_hi_ff[2:0], addr_lo_ff};
  wire [13:0] arr_rd;
  wire key_ok = (key_ff == 2'h2);
  wire ctrl_wr = wr_hit(i_addr, `FSP_CONTROL, i_wr);
  wire trig_req = ctrl_wr && i_wdata[`FSP_B_PROG];
  // modify-enable and unlock order both required
  wire trig_ok = trig_req && ctrl_ff[`FSP_B_MODIFY] && key_ok
    && (state_ff == ST_IDLE) && ctrl_ff[`FSP_B_PGM_SEL]
    && !ctrl_ff[`FSP_B_CFG_SEL];
  // reads are served in the done cycle too, as the core runs again there
  wire start_rd = ctrl_wr && i_wdata[`FSP_B_READ] && !halting(state_ff)
    && i_wdata[`FSP_B_PGM_SEL] && !i_wdata[`FSP_B_CFG_SEL];
  wire do_erase = (state_ff == ST_BUSY) && (op_ff == OP_ERASE)
    && (cnt_ff == PROG_LAST);
  wire do_prog = (state_ff == ST_COMMIT);
  // the core stalls through setup, the long cycle and the commit only
  assign o_core_halt = halting(state_ff);
  assign o_skip_slot = rd_pipe_ff[0];
  // ------------------------------------------------------------
  // unlock key tracker
  // ------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      key_ff <= 2'h0;
    end else if (wr_hit(i_addr, `FSP_UNLOCK, i_wr)) begin
      if (i_wdata == `FSP_KEY_FIRST) begin
        key_ff <= 2'h1;
      end else if (i_wdata == `FSP_KEY_SECOND && key_ff == 2'h1) begin
        key_ff <= 2'h2;
      end else begin
        key_ff <= 2'h0;
      end
    end else if (i_wr) begin
      // any other write breaks the sequence, so no stale unlock survives
      key_ff <= 2'h0;
    end
  end
  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (trig_ok && !ctrl_ff[`FSP_B_LATCH_ONLY]) begin
          nxt_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_ff[0]) begin
          nxt_state = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (cnt_ff == PROG_LAST) begin
          nxt_state = (op_ff == OP_WRITE) ? ST_COMMIT : ST_DONE;
        end
      end
      ST_COMMIT: begin
        if (lat_idx_ff == 5'h1F) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state_ff <= ST_IDLE;
      op_ff <= OP_ERASE;
      cnt_ff <= 28'h0000000;
      lat_idx_ff <= 5'h00;
    end else begin
      state_ff <= nxt_state;
      if (state_ff != nxt_state) begin
        cnt_ff <= 28'h0000000;
      end else begin
        cnt_ff <= cnt_ff + 28'h0000001;
      end
      // the job is fixed at the trigger; later control writes cannot alter it
      if (trig_ok) begin
        if (ctrl_ff[`FSP_B_ERASE]) begin
          op_ff <= OP_ERASE;
        end else if (ctrl_ff[`FSP_B_LATCH_ONLY]) begin
          op_ff <= OP_LOAD;
        end else begin
          op_ff <= OP_WRITE;
        end
      end
      if (do_prog) begin
        lat_idx_ff <= lat_idx_ff + 5'h01;
      end else begin
        lat_idx_ff <= 5'h00;
      end
    end
  end
  // ------------------------------------------------------------
  // write latches
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_lat
      always @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
          latch_ff[g] <= `FSP_LATCH_RST;
        end else if (state_ff == ST_DONE && op_ff == OP_WRITE) begin
          latch_ff[g] <= `FSP_LATCH_RST;
        end else if (trig_ok && !ctrl_ff[`FSP_B_ERASE]
          && addr_lo_ff[4:0] == g) begin
          latch_ff[g] <= {word_hi_ff, word_lo_ff};
        end
      end
    end
  endgenerate
  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      addr_lo_ff <= 8'h00;
      addr_hi_ff <= 6'h00;
      word_lo_ff <= 8'h00;
      word_hi_ff <= 6'h00;
      ctrl_ff <= `FSP_CONTROL_RST;
      rd_pipe_ff <= 2'h0;
    end else begin
      rd_pipe_ff <= {rd_pipe_ff[0], start_rd};
      if (wr_hit(i_addr, `FSP_ADDR_LOW, i_wr)) begin
        addr_lo_ff <= i_wdata;
      end
      if (wr_hit(i_addr, `FSP_ADDR_HIGH, i_wr)) begin
        addr_hi_ff <= i_wdata[5:0];
      end
      if (rd_pipe_ff[0]) begin
        word_lo_ff <= arr_rd[7:0];
        word_hi_ff <= arr_rd[13:8];
      end else begin
        if (wr_hit(i_addr, `FSP_WORD_LOW, i_wr)) begin
          word_lo_ff <= i_wdata;
        end
        if (wr_hit(i_addr, `FSP_WORD_HIGH, i_wr)) begin
          word_hi_ff <= i_wdata[5:0];
        end
      end
      if (ctrl_wr) begin
        // trigger and erase bits are hardware owned while busy
        ctrl_ff[`FSP_B_MODIFY] <= i_wdata[`FSP_B_MODIFY];
        ctrl_ff[`FSP_B_LATCH_ONLY] <= i_wdata[`FSP_B_LATCH_ONLY];
        ctrl_ff[`FSP_B_CFG_SEL] <= i_wdata[`FSP_B_CFG_SEL];
        ctrl_ff[`FSP_B_PGM_SEL] <= i_wdata[`FSP_B_PGM_SEL];
        if (state_ff == ST_IDLE) begin
          ctrl_ff[`FSP_B_ERASE] <= i_wdata[`FSP_B_ERASE];
        end
      end
      if (start_rd) begin
        ctrl_ff[`FSP_B_READ] <= 1'b1;
      end else if (rd_pipe_ff[0]) begin
        ctrl_ff[`FSP_B_READ] <= 1'b0;
      end
      if (trig_ok && !ctrl_ff[`FSP_B_LATCH_ONLY]) begin
        ctrl_ff[`FSP_B_PROG] <= 1'b1;
      end else if (state_ff == ST_DONE) begin
        ctrl_ff[`FSP_B_PROG] <= 1'b0;
        if (op_ff == OP_ERASE) begin
          ctrl_ff[`FSP_B_ERASE] <= 1'b0;
        end
      end
    end
  end
  // ------------------------------------------------------------
  // read data, one cycle after the strobe
  // ------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `FSP_ADDR_LOW: o_rdata <= addr_lo_ff;
        `FSP_ADDR_HIGH: o_rdata <= {2'h0, addr_hi_ff};
        `FSP_WORD_LOW: o_rdata <= word_lo_ff;
        `FSP_WORD_HIGH: o_rdata <= {2'h0, word_hi_ff};
        `FSP_CONTROL: o_rdata <= ctrl_ff;
        `FSP_STATUS: o_rdata <= {5'h00, state_ff};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
  // ------------------------------------------------------------
  // flash array; writes never erase first, they only clear bits
  // ------------------------------------------------------------
  fsp_flash_array u_array (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_rd_addr(full_addr),
    .o_rd_data(arr_rd),
    .i_erase(do_erase),
    .i_row(full_addr[10:5]),
    .i_prog(do_prog),
    .i_prog_addr({full_addr[10:5], lat_idx_ff}),
    .i_prog_data(latch_ff[lat_idx_ff])
  );
  wire unused_cp = i_code_protect;
endmodule
`default_nettype wire

/* src/fsp_consts.vh */
// constants for the flash self-program controller
`ifndef FSP_CONSTS_VH
`define FSP_CONSTS_VH
// ------------------------------------------------------------
// register offsets on the plain register port
// ------------------------------------------------------------
`define FSP_ADDR_LOW 3'h0
`define FSP_ADDR_HIGH 3'h1
`define FSP_WORD_LOW 3'h2
`define FSP_WORD_HIGH 3'h3
`define FSP_CONTROL 3'h4
`define FSP_UNLOCK 3'h5
`define FSP_STATUS 3'h6
// ------------------------------------------------------------
// control field positions
// ------------------------------------------------------------
`define FSP_B_READ 0
`define FSP_B_PROG 1
`define FSP_B_MODIFY 2
`define FSP_B_ERASE 4
`define FSP_B_LATCH_ONLY 5
`define FSP_B_CFG_SEL 6
`define FSP_B_PGM_SEL 7
// ------------------------------------------------------------
// reset values and fixed patterns
// ------------------------------------------------------------
`define FSP_CONTROL_RST 8'h00
`define FSP_KEY_FIRST 8'h55
`define FSP_KEY_SECOND 8'hAA
`define FSP_LATCH_RST 14'h3FFF
`define FSP_ERASED 14'h3FFF
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define FSP_CLK_MHZ 100
`define FSP_PROG_TIME_US 2000
`define FSP_PROG_CYCLES (`FSP_PROG_TIME_US * `FSP_CLK_MHZ)
`define FSP_SETUP_CYCLES 2
`endif

/* src/fsp_flash_array.v */
// flash word array held in flip-flops, row erase and one-word program
`default_nettype none
module fsp_flash_array (
  // clock and reset
  input wire i_clk_sys,
  input wire i_rst_b,
  // read port
  input wire [10:0] i_rd_addr,
  output wire [13:0] o_rd_data,
  // erase row strobe
  input wire i_erase,
  input wire [5:0] i_row,
  // program one word strobe
  input wire i_prog,
  input wire [10:0] i_prog_addr,
  input wire [13:0] i_prog_data
);
`include "fsp_consts.vh"
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  // size kept to 2k words; programming only clears bits like real flash
  reg [13:0] mem_ff [0:2047];
  integer k;
  assign o_rd_data = mem_ff[i_rd_addr];
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      for (k = 0; k < 2048; k = k + 1) begin
        mem_ff[k] <= `FSP_ERASED;
      end
    end else if (i_erase) begin
      for (k = 0; k < 32; k = k + 1) begin
        mem_ff[{i_row, k[4:0]}] <= `FSP_ERASED;
      end
    end else if (i_prog) begin
      mem_ff[i_prog_addr] <= mem_ff[i_prog_addr] & i_prog_data;
    end
  end
endmodule
`default_nettype wire

/* tb/fsp_ctrl_monitor.sv */
// assertion checker for the flash self-program controller
`default_nettype none
`include "fsp_consts.vh"
module fsp_ctrl_monitor #(
  parameter PROG_CYCLES = 20
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // core control
  input wire logic i_code_protect,
  input wire logic o_core_halt,
  input wire logic o_skip_slot
);
  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  logic ctl_wr;
  logic rd_busy;
  logic [27:0] halt_cnt_ff;
  assign ctl_wr = i_wr && i_addr == `FSP_CONTROL;
  assign rd_busy = i_rd && i_addr == `FSP_CONTROL && o_core_halt;
  // counts halt cycles so long stalls need no long repetition
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || !o_core_halt) halt_cnt_ff <= 28'h0000000;
    else halt_cnt_ff <= halt_cnt_ff + 28'h0000001;
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  a_read_slot: assert property (ctl_wr && i_wdata[`FSP_B_READ] &&
    i_wdata[`FSP_B_PGM_SEL] && !i_wdata[`FSP_B_CFG_SEL] && !o_core_halt
    |=> o_skip_slot) else $error("read trigger gave no skipped slot");
  a_slot_cause: assert property (o_skip_slot |-> $past(ctl_wr) &&
    $past(i_wdata[`FSP_B_READ])) else $error("skip slot without read");
  a_read_no_stall: assert property (o_skip_slot |-> !o_core_halt)
    else $error("read stalled the core");
  a_halt_cause: assert property ($rose(o_core_halt) |-> $past(ctl_wr) &&
    $past(i_wdata[`FSP_B_PROG]) && $past(i_wdata[`FSP_B_MODIFY]))
    else $error("halt without enabled trigger");
  a_latch_no_stall: assert property (ctl_wr &&
    i_wdata[`FSP_B_LATCH_ONLY] && !o_core_halt |=> !o_core_halt)
    else $error("latch load stalled the core");
  a_setup_hold: assert property ($rose(o_core_halt)
    |-> o_core_halt [*8]) else $error("halt dropped during setup");
  a_halt_long: assert property ($fell(o_core_halt)
    |-> $past(halt_cnt_ff) >= PROG_CYCLES) else $error("halt too short");
  a_halt_bounded: assert property (halt_cnt_ff <= PROG_CYCLES + 40)
    else $error("halt too long");
  a_trig_visible: assert property ($past(rd_busy)
    |-> o_rdata[`FSP_B_PROG]) else $error("trigger clear while busy");
endmodule
bind fsp_ctrl fsp_ctrl_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon (
  .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_code_protect(i_code_protect), .o_core_halt(o_core_halt),
  .o_skip_slot(o_skip_slot));
`default_nettype wire

/* tb/flash_self_program_controller_test.sv */
// self-checking bench for the flash self-program controller
`default_nettype none
`include "fsp_consts.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module flash_self_program_controller_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals and device
  // ------------------------------------------------------------
  localparam int PC = 20;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_code_protect = 1'b1;
  logic [7:0] o_rdata;
  logic o_core_halt;
  logic o_skip_slot;
  logic [7:0] d;
  logic [13:0] w;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  fsp_ctrl #(.PROG_CYCLES(PC)) dut (.i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_code_protect(i_code_protect),
    .o_core_halt(o_core_halt), .o_skip_slot(o_skip_slot));
  always #5 i_clk_sys = ~i_clk_sys;
  // whole run needs well under two thousand cycles
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      test_done();
    end
  end
  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  task automatic rd(input logic [2:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    @(posedge i_clk_sys);
  endtask
  task automatic rdw(input logic [10:0] a, input logic [13:0] e);
    logic [7:0] lo;
    wr(`FSP_ADDR_LOW, a[7:0]);
    wr(`FSP_ADDR_HIGH, {5'h00, a[10:8]});
    i_addr <= `FSP_CONTROL;
    i_wdata <= 8'h81;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1 `CHK(o_skip_slot, 1'b1)
    @(posedge i_clk_sys);
    #1 `CHK(o_skip_slot, 1'b0)
    @(posedge i_clk_sys);
    rd(`FSP_WORD_LOW);
    lo = d;
    rd(`FSP_WORD_HIGH);
    `CHK({d[5:0], lo}, e)
  endtask
  // key order is an argument so refusals share the same path
  task automatic ldw(input logic [10:0] a, input logic [13:0] v,
    input logic [7:0] ctl, input logic [7:0] k1, input logic [7:0] k2);
    wr(`FSP_CONTROL, ctl & 8'hFD);
    wr(`FSP_ADDR_LOW, a[7:0]);
    wr(`FSP_ADDR_HIGH, {5'h00, a[10:8]});
    wr(`FSP_WORD_LOW, v[7:0]);
    wr(`FSP_WORD_HIGH, {2'h0, v[13:8]});
    wr(`FSP_UNLOCK, k1);
    wr(`FSP_UNLOCK, k2);
    wr(`FSP_CONTROL, ctl);
  endtask
  task automatic busy_then_idle(input logic er);
    int n;
    rd(`FSP_CONTROL);
    `CHK(d[`FSP_B_PROG], 1'b1)
    `CHK(d[`FSP_B_ERASE], er)
    n = 0;
    while (o_core_halt !== 1'b0 && n < 200) begin
      @(posedge i_clk_sys);
      #1 n++;
    end
    `CHK(o_core_halt, 1'b0)
    @(posedge i_clk_sys);
    rd(`FSP_CONTROL);
    `CHK(d[`FSP_B_PROG], 1'b0)
    `CHK(d[`FSP_B_ERASE], 1'b0)
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_read();
    rd(`FSP_CONTROL);
    `CHK(d, `FSP_CONTROL_RST)
    rdw(11'h005, `FSP_ERASED);
    i_code_protect <= 1'b0;
    rdw(11'h7FF, `FSP_ERASED);
    $display("test read done");
  endtask
  task automatic test_write();
    ldw(11'h020, 14'h1234, 8'hA6, `FSP_KEY_FIRST, `FSP_KEY_SECOND);
    ldw(11'h021, 14'h0ABC, 8'hA6, `FSP_KEY_FIRST, `FSP_KEY_SECOND);
    ldw(11'h03F, 14'h2F0F, 8'h86, `FSP_KEY_FIRST, `FSP_KEY_SECOND);
    busy_then_idle(1'b0);
    rdw(11'h020, 14'h1234);
    rdw(11'h021, 14'h0ABC);
    rdw(11'h022, `FSP_ERASED);
    ldw(11'h05F, 14'h1111, 8'h86, `FSP_KEY_FIRST, `FSP_KEY_SECOND);
    busy_then_idle(1'b0);
    rdw(11'h040, `FSP_LATCH_RST);
    rdw(11'h05F, 14'h1111);
    ldw(11'h020, 14'h0FF0, 8'h86, `FSP_KEY_FIRST, `FSP_KEY_SECOND);
    busy_then_idle(1'b0);
    rdw(11'h020, 14'h0230);
    $display("test write done");
  endtask
  task automatic test_refuse();
    ldw(11'h060, 14'h0000, 8'h82, `FSP_KEY_FIRST, `FSP_KEY_SECOND);
    rdw(11'h060, `FSP_ERASED);
    ldw(11'h060, 14'h0000, 8'h86, `FSP_KEY_SECOND, `FSP_KEY_FIRST);
    rdw(11'h060, `FSP_ERASED);
    $display("test refuse done");
  endtask
  task automatic test_erase();
    ldw(11'h035, 14'h0000, 8'h96, `FSP_KEY_FIRST, `FSP_KEY_SECOND);
    busy_then_idle(1'b1);
    rdw(11'h020, `FSP_ERASED);
    rdw(11'h03F, `FSP_ERASED);
    rdw(11'h05F, 14'h1111);
    $display("test erase done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    @(posedge i_clk_sys);
    test_read();
    test_write();
    test_refuse();
    test_erase();
    test_done();
  end
endmodule
`default_nettype wire
